// ===== hw/sas_pkg.sv
// Package: constants, state codes and timing helpers for the sequencer
package sas_pkg;

  // ----------------------------------------------------------------
  // Register layout and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [2:0] CHAN_RESET = 3'h0;
  localparam int         ENABLE_BIT = 7;
  localparam int         TIME_LSB   = 3;
  localparam int         TIME_MSB   = 5;
  localparam int         RES_W      = 10;
  localparam logic [3:0] TOP_BIT    = 4'h9;
  localparam logic [9:0] SAR_START  = 10'h200;

  // ----------------------------------------------------------------
  // Conversion time codes and lengths in main clock cycles
  // ----------------------------------------------------------------
  localparam logic [2:0] TIME_144 = 3'h0;
  localparam logic [2:0] TIME_120 = 3'h1;
  localparam logic [2:0] TIME_96  = 3'h2;
  localparam logic [2:0] TIME_72  = 3'h4;
  localparam logic [2:0] TIME_60  = 3'h5;
  localparam logic [2:0] TIME_48  = 3'h6;
  localparam logic [7:0] CYC_144  = 8'h90;
  localparam logic [7:0] CYC_120  = 8'h78;
  localparam logic [7:0] CYC_96   = 8'h60;
  localparam logic [7:0] CYC_72   = 8'h48;
  localparam logic [7:0] CYC_60   = 8'h3C;
  localparam logic [7:0] CYC_48   = 8'h30;
  // Sampling takes one tenth of the conversion period
  localparam logic [7:0] SAMPLE_DIV = 8'h0A;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SAMPLE  = 2'b01,
    ST_COMPARE = 2'b10,
    ST_LATCH   = 2'b11
  } sas_state_t;

  // Prohibited codes fall back to the slowest, safest setting
  function automatic logic [7:0] conv_cycles(input logic [2:0] code);
    case (code)
      TIME_120: conv_cycles = CYC_120;
      TIME_96:  conv_cycles = CYC_96;
      TIME_72:  conv_cycles = CYC_72;
      TIME_60:  conv_cycles = CYC_60;
      TIME_48:  conv_cycles = CYC_48;
      default:  conv_cycles = CYC_144;
    endcase
  endfunction

  function automatic logic [7:0] samp_cycles(input logic [2:0] code);
    samp_cycles = conv_cycles(code) / SAMPLE_DIV;
  endfunction

  function automatic logic [7:0] step_cycles(input logic [2:0] code);
    step_cycles = (conv_cycles(code) - samp_cycles(code)) / SAMPLE_DIV;
  endfunction

endpackage

// ===== hw/sas_sequencer.sv
// Successive-approximation converter sequencer with plain register ports
`timescale 1ns/1ps

// Contract
// (R1) After reset, idle in select mode; channel register picks one of eight.
// (R2) Conversion starts only from a software mode register write; code also starts on channel writes and after standby if enabled.
// (R3) Writing enable bit 7 as one starts converting the selected channel.
// (R4) Completion loads the result register and pulses the end request together.
// (R5) Conversions repeat back to back until the mode register is rewritten.
// (R6) Mode write with enable set aborts and restarts with new settings.
// (R7) Mode write with enable clear halts conversion at once.
// (R8) Standby stops the converter.
// (R9) Result read coinciding with completion is served first; write follows.
// (R10) Mode or channel write at completion wins; no result, no request.
// (R11) Software discards the first result after every start.
// (R12) Software reads while running, or stops before next completion.
// (R13) About one tenth of each conversion is spent sampling.
// (R14) Mode writes never clear the end flag.
// (R15) Software clears the end flag before restarting.
// (R16) Software avoids port reads on the pin selected for conversion.
// (R17) Ten bits resolved MSB first, then final value latched.
// (R18) Channel write cancels conversion; restarts if enable is set.
// (R19) Reset clears the mode register to zero, conversion disabled.
// (R20) Conversion length is fixed cycles chosen by the time field.
// (R21) End flag sets on each stored result and holds until cleared.
module sas_sequencer (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Processor side
  input  wire logic        mode_wr,
  input  wire logic [7:0]  mode_wdata,
  input  wire logic        chan_wr,
  input  wire logic [2:0]  chan_wdata,
  input  wire logic        result_rd,
  input  wire logic        flag_clr,
  input  wire logic        standby,
  output logic      [7:0]  converter_mode_reg,
  output logic      [2:0]  channel_select_reg,
  output logic      [9:0]  conversion_result_reg,
  output logic             conversion_end_flag,
  output logic             conversion_end_irq,
  output logic             busy,
  output logic      [7:0]  shared_port_pins_busy,
  // Analog side
  input  wire logic        cmp_in,
  output logic             sample_en,
  output logic      [2:0]  analog_sel,
  output logic      [9:0]  trial_code
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    sas_pkg::sas_state_t st;
    logic [7:0]          mode;
    logic [2:0]          chan;
    logic [9:0]          result;
    logic [9:0]          sar;
    logic [3:0]          bitn;
    logic [7:0]          cnt;
    logic                flag;
    logic                irq;
    logic [2:0]          sync;
    logic                cmp;
  } sas_regs_t;

  sas_regs_t   r_reg;
  sas_regs_t   r_next;
  logic [2:0]  time_code;
  logic [7:0]  samp;
  logic [7:0]  step;
  logic [9:0]  fin;
  logic        wr_any;
  logic        en_next;
  logic        cmp_ok;

  assign time_code = r_reg.mode[sas_pkg::TIME_MSB:sas_pkg::TIME_LSB];
  assign samp      = sas_pkg::samp_cycles(time_code);
  assign step      = sas_pkg::step_cycles(time_code);
  assign wr_any    = mode_wr | chan_wr;
  assign en_next   = mode_wr ? mode_wdata[sas_pkg::ENABLE_BIT] // R3
                             : r_reg.mode[sas_pkg::ENABLE_BIT];

  // Agreed level taken at once; the registered copy lags one cycle,
  // too late for the four-cycle steps of the fastest time code
  assign cmp_ok = (r_reg.sync[1] == r_reg.sync[2]) ? r_reg.sync[2]
                                                   : r_reg.cmp;

  // Current bit decided from the filtered comparator
  always_comb
  begin
    fin = r_reg.sar;
    if (!cmp_ok) // R17
      fin[r_reg.bitn] = 1'b0;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    r_next     = r_reg;
    r_next.irq = 1'b0;
    // Comparator is asynchronous to clk; accept a level once stable
    r_next.sync = {r_reg.sync[1:0], cmp_in};
    if (r_reg.sync[1] == r_reg.sync[2])
      r_next.cmp = r_reg.sync[2];
    if (flag_clr)
      r_next.flag = 1'b0;

    case (r_reg.st)
      sas_pkg::ST_IDLE:
      begin
        r_next.cnt = 8'h00;
      end
      sas_pkg::ST_SAMPLE:
      begin
        r_next.cnt = r_reg.cnt + 8'h01;
        if (r_reg.cnt == samp - 8'h01) // R13
        begin
          r_next.st   = sas_pkg::ST_COMPARE;
          r_next.cnt  = 8'h00;
          r_next.bitn = sas_pkg::TOP_BIT; // R17
          r_next.sar  = sas_pkg::SAR_START;
        end
      end
      sas_pkg::ST_COMPARE:
      begin
        r_next.cnt = r_reg.cnt + 8'h01;
        if (r_reg.cnt == step - 8'h01) // R20
        begin
          r_next.cnt = 8'h00;
          r_next.sar = fin;
          if (r_reg.bitn != 4'h0)
          begin
            r_next.bitn = r_reg.bitn - 4'h1;
            r_next.sar[r_reg.bitn - 4'h1] = 1'b1; // R17
          end
          else if (result_rd)
          begin
            // Let the read see the old value first
            r_next.st = sas_pkg::ST_LATCH; // R9
          end
          else
          begin
            r_next.result = fin; // R4
            r_next.irq    = 1'b1; // R4
            r_next.flag   = 1'b1; // R21
            r_next.st     = sas_pkg::ST_SAMPLE; // R5
          end
        end
      end
      sas_pkg::ST_LATCH:
      begin
        r_next.result = r_reg.sar; // R9
        r_next.irq    = 1'b1; // R4
        r_next.flag   = 1'b1; // R21
        r_next.st     = sas_pkg::ST_SAMPLE; // R5
        r_next.cnt    = 8'h00;
      end
      default:
      begin
        r_next.st = sas_pkg::ST_IDLE;
      end
    endcase

    // Register writes override a completion in the same cycle
    if (mode_wr)
      r_next.mode = mode_wdata; // R14
    if (chan_wr)
      r_next.chan = chan_wdata; // R1
    if (wr_any)
    begin
      r_next.result = r_reg.result; // R10
      r_next.irq    = 1'b0; // R10
      r_next.flag   = r_reg.flag & ~flag_clr; // R14
      r_next.cnt    = 8'h00;
      r_next.st     = en_next ? sas_pkg::ST_SAMPLE // R6 R18
                              : sas_pkg::ST_IDLE; // R7
    end
    else if (r_reg.st == sas_pkg::ST_IDLE && en_next)
      r_next.st = sas_pkg::ST_SAMPLE; // R2

    // Standby aborts; conversion resumes from sampling afterwards
    if (standby)
    begin
      r_next.st     = sas_pkg::ST_IDLE; // R8
      r_next.cnt    = 8'h00;
      r_next.irq    = 1'b0;
      r_next.result = r_reg.result;
      r_next.flag   = r_reg.flag & ~flag_clr;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      r_reg.st     <= sas_pkg::ST_IDLE; // R1
      r_reg.mode   <= sas_pkg::MODE_RESET; // R19
      r_reg.chan   <= sas_pkg::CHAN_RESET; // R1
      r_reg.result <= '0;
      r_reg.sar    <= '0;
      r_reg.bitn   <= '0;
      r_reg.cnt    <= '0;
      r_reg.flag   <= 1'b0;
      r_reg.irq    <= 1'b0;
      r_reg.sync   <= '0;
      r_reg.cmp    <= 1'b0;
    end
    else
      r_reg <= r_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign converter_mode_reg    = r_reg.mode;
  assign channel_select_reg    = r_reg.chan;
  assign conversion_result_reg = r_reg.result;
  assign conversion_end_flag   = r_reg.flag;
  assign conversion_end_irq    = r_reg.irq;
  assign busy                  = r_reg.st != sas_pkg::ST_IDLE;
  assign sample_en             = r_reg.st == sas_pkg::ST_SAMPLE;
  assign analog_sel            = r_reg.chan;
  assign trial_code            = r_reg.sar;
  // Tells port logic which pin must not be read digitally
  assign shared_port_pins_busy =
    r_reg.mode[sas_pkg::ENABLE_BIT] ? 8'(8'h01 << r_reg.chan) : 8'h00;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_start_req;
    mode_wr && mode_wdata[sas_pkg::ENABLE_BIT] && !standby;
  endsequence

  sequence s_fresh_sample;
    r_reg.st == sas_pkg::ST_SAMPLE && r_reg.cnt == 8'h00;
  endsequence

  sequence s_done;
    r_reg.st == sas_pkg::ST_COMPARE && r_reg.bitn == 4'h0 &&
    r_reg.cnt == step - 8'h01 && !wr_any && !standby;
  endsequence

  a_start_on_write: assert property (s_start_req |=> s_fresh_sample) // R3
    else $error("enabled mode write did not restart sampling");

  a_stop_on_clear: assert property ( // R7
    mode_wr && !mode_wdata[sas_pkg::ENABLE_BIT] |=>
      r_reg.st == sas_pkg::ST_IDLE)
    else $error("disabled mode write did not halt");

  a_standby_stop: assert property ( // R8
    standby |=> r_reg.st == sas_pkg::ST_IDLE && !r_reg.irq)
    else $error("converter ran during standby");

  a_chan_cancel: assert property ( // R18
    chan_wr && !mode_wr && !standby |=>
      r_reg.cnt == 8'h00 && (r_reg.st == sas_pkg::ST_SAMPLE) ==
      $past(r_reg.mode[sas_pkg::ENABLE_BIT]))
    else $error("channel write did not cancel conversion");

  a_result_irq: assert property ( // R4
    $changed(r_reg.result) |-> r_reg.irq && r_reg.flag)
    else $error("result changed without end request");

  a_done_next: assert property ( // R5
    (s_done and !result_rd) |=> r_reg.irq ##0 s_fresh_sample)
    else $error("completion did not store and restart");

  a_read_first: assert property ( // R9
    (s_done and result_rd) |=> $stable(r_reg.result) ##1 r_reg.irq)
    else $error("read did not precede result write");

  a_write_wins: assert property ( // R10
    wr_any |=> !r_reg.irq && $stable(r_reg.result))
    else $error("register write lost to completion");

  a_flag_sticky: assert property ( // R14
    r_reg.flag && !flag_clr |=> r_reg.flag)
    else $error("end flag dropped without clear");

  a_ten_bits: assert property ( // R17
    $rose(r_reg.st == sas_pkg::ST_COMPARE) |->
      r_reg.bitn == sas_pkg::TOP_BIT && r_reg.sar == sas_pkg::SAR_START)
    else $error("approximation did not start at top bit");

  a_sample_len: assert property ( // R13
    r_reg.st == sas_pkg::ST_SAMPLE |-> r_reg.cnt < samp)
    else $error("sampling phase overran");

  a_irq_pulse: assert property ( // R4
    r_reg.irq |=> !r_reg.irq)
    else $error("end request held longer than one cycle");

  a_idle_hold: assert property ( // R2
    r_reg.st == sas_pkg::ST_IDLE && !mode_wr &&
    !r_reg.mode[sas_pkg::ENABLE_BIT] |=> r_reg.st == sas_pkg::ST_IDLE)
    else $error("conversion began without a mode write");

endmodule // sas_sequencer

// ===== testbench/sas_analog_model.sv
// Behavioural sample-and-hold, comparator and ladder beside the sequencer
`timescale 1ns/1ps

module sas_analog_model (
  // Converter side
  input  wire logic       clk,
  input  wire logic       sample_en,
  input  wire logic [2:0] analog_sel,
  input  wire logic [9:0] trial_code,
  output logic            cmp_in,
  // Source level of each input, as an ideal code
  input  wire logic [9:0] vin [8]
);
  logic [9:0] held;

  // Tracks only while sampling, so a late input change cannot leak in
  always_ff @(posedge clk)
    if (sample_en)
      held <= vin[analog_sel];

  assign cmp_in = (held >= trial_code);
endmodule // sas_analog_model

// ===== testbench/test_sas_sequencer.sv
// Self-checking testbench for the converter sequencer
`timescale 1ns/1ps

module test_sas_sequencer;
  // ----------------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------------
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       mode_wr = 1'b0;
  logic [7:0] mode_wdata = 8'h00;
  logic       chan_wr = 1'b0;
  logic [2:0] chan_wdata = 3'h0;
  logic       result_rd = 1'b0;
  logic       flag_clr = 1'b0;
  logic       standby = 1'b0;
  logic [7:0] mode_q, pins_q;
  logic [2:0] chan_q, sel;
  logic [9:0] result_q, trial, old;
  logic       flag_q, irq_q, busy_q, cmp, samp_en;
  logic [9:0] vin [8];
  logic [2:0] codes [6] = '{sas_pkg::TIME_144, sas_pkg::TIME_120,
    sas_pkg::TIME_96, sas_pkg::TIME_72, sas_pkg::TIME_60, sas_pkg::TIME_48};
  int         cyc [6] = '{sas_pkg::CYC_144, sas_pkg::CYC_120,
    sas_pkg::CYC_96, sas_pkg::CYC_72, sas_pkg::CYC_60, sas_pkg::CYC_48};
  int         miscompares = 0;
  int         num_checks = 0;
  int         n, s, t;

  always #2.5 clk = ~clk;

  sas_sequencer uut (.clk(clk), .rst(rst), .mode_wr(mode_wr),
    .mode_wdata(mode_wdata), .chan_wr(chan_wr), .chan_wdata(chan_wdata),
    .result_rd(result_rd), .flag_clr(flag_clr), .standby(standby),
    .converter_mode_reg(mode_q), .channel_select_reg(chan_q),
    .conversion_result_reg(result_q), .conversion_end_flag(flag_q),
    .conversion_end_irq(irq_q), .busy(busy_q),
    .shared_port_pins_busy(pins_q), .cmp_in(cmp), .sample_en(samp_en),
    .analog_sel(sel), .trial_code(trial));

  sas_analog_model far_side (.clk(clk), .sample_en(samp_en),
    .analog_sel(sel), .trial_code(trial), .cmp_in(cmp), .vin(vin));

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %s got %0h want %0h", $time, what, got,
               exp);
    end
  endtask

  // Strobes last exactly one cycle, launched and dropped at falling edges
  task automatic drive(input logic mw, input logic [7:0] md, input logic cw,
                       input logic [2:0] cd, input logic rd, input logic fc);
    mode_wdata = md;
    chan_wdata = cd;
    // Only raised strobes are touched, so back-to-back calls raising different
    // strobes never assign one strobe twice at the same falling edge
    if (mw) mode_wr = 1'b1;
    if (cw) chan_wr = 1'b1;
    if (rd) result_rd = 1'b1;
    if (fc) flag_clr = 1'b1;
    @(negedge clk);
    if (mw) mode_wr = 1'b0;
    if (cw) chan_wr = 1'b0;
    if (rd) result_rd = 1'b0;
    if (fc) flag_clr = 1'b0;
  endtask

  // Counts cycles to the end request, and sampling cycles on the way
  task automatic wait_irq(input int lim, input bit must);
    n = 0;
    s = 0;
    do
    begin
      @(negedge clk);
      n++;
      if (samp_en === 1'b1)
        s++;
    end
    while (irq_q !== 1'b1 && n < lim);
    if (must && n >= lim)
    begin
      miscompares++;
      $display("wrong value at %0t: no end request", $time);
      results();
    end
  endtask

  function automatic int period(input int c);
    return c / 10 + 10 * ((c - c / 10) / 10);
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 8; i++)
      vin[i] = 10'(i * 131 + 5);
    vin[0] = 10'h3FF;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    check(mode_q, sas_pkg::MODE_RESET, "mode at reset");
    check(chan_q, sas_pkg::CHAN_RESET, "channel at reset");
    check({busy_q, flag_q, irq_q, pins_q}, 11'h000, "idle");
    wait_irq(100, 1'b0);
    check(n, 100, "start without write");
    $display("test reset finished at %0t", $time);
    for (int k = 0; k < 6; k++)
    begin
      t = period(cyc[k]);
      drive(1'b1, {2'b10, codes[k], 3'h0}, 1'b1, 3'(k + 2), 1'b0, 1'b0);
      check(pins_q, 8'h01 << (k + 2), "pin in use");
      wait_irq(400, 1'b1);
      check(n, t, "first length");
      check(s, cyc[k] / 10, "sampling length");
      wait_irq(400, 1'b1);
      check(n, t, "repeat length");
      check(result_q, vin[k + 2], "result");
      check(flag_q, 1'b1, "end flag");
    end
    $display("test time codes finished at %0t", $time);
    drive(1'b1, 8'h80, 1'b0, 3'h0, 1'b0, 1'b0);
    check(flag_q, 1'b1, "flag after mode write");
    drive(1'b0, 8'h00, 1'b0, 3'h0, 1'b0, 1'b1);
    check(flag_q, 1'b0, "flag cleared");
    wait_irq(400, 1'b1);
    check(n, period(144) - 1, "new time used");
    repeat (20) @(negedge clk);
    drive(1'b0, 8'h00, 1'b1, 3'h1, 1'b0, 1'b0);
    wait_irq(400, 1'b1);
    check(n, period(144), "channel restart");
    check(result_q, vin[1], "new channel result");
    $display("test restart finished at %0t", $time);
    old = result_q;
    repeat (period(144) - 1) @(negedge clk);
    drive(1'b0, 8'h00, 1'b0, 3'h0, 1'b1, 1'b0);
    check(irq_q, 1'b0, "read served first");
    wait_irq(10, 1'b1);
    check(n, 1, "deferred result write");
    vin[1] = 10'h000;
    drive(1'b1, 8'h80, 1'b0, 3'h0, 1'b0, 1'b0);
    repeat (period(144) - 1) @(negedge clk);
    drive(1'b1, 8'h80, 1'b0, 3'h0, 1'b0, 1'b0);
    check({irq_q, result_q}, {1'b0, old}, "write wins");
    wait_irq(400, 1'b1);
    check(result_q, 10'h000, "result after restart");
    drive(1'b1, 8'h98, 1'b0, 3'h0, 1'b0, 1'b0);
    wait_irq(400, 1'b1);
    check(n, period(144), "prohibited code");
    $display("test collisions finished at %0t", $time);
    repeat (30) @(negedge clk);
    drive(1'b1, 8'h00, 1'b0, 3'h0, 1'b0, 1'b0);
    check({busy_q, pins_q}, 9'h000, "stopped");
    wait_irq(300, 1'b0);
    check(n, 300, "no result after stop");
    drive(1'b1, 8'hB0, 1'b0, 3'h0, 1'b0, 1'b0);
    repeat (10) @(negedge clk);
    standby = 1'b1;
    @(negedge clk);
    check(busy_q, 1'b0, "standby stops");
    wait_irq(100, 1'b0);
    check(n, 100, "no result in standby");
    standby = 1'b0;
    wait_irq(100, 1'b1);
    check(n, period(48) + 1, "resume after standby");
    $display("test stop and standby finished at %0t", $time);
    results();
  end
endmodule // test_sas_sequencer
